// ==== sdm_pkg.sv ====
// sdm_pkg: constants and types shared by the serial debug memory command engine.
// assumes a single system clock domain; the serial link clock is sampled, not used as a clock.
package sdm_pkg;

  // ****************************************************************
  // serial frame and responses
  // ****************************************************************
  localparam int FRAME_BITS = 17;
  localparam logic [16:0] RSP_COMPLETE = 17'h0FFFF;
  localparam logic [16:0] RSP_NOT_READY = 17'h10000;
  localparam logic [16:0] RSP_BUS_ERROR = 17'h10001;
  localparam logic [16:0] RSP_ILLEGAL = 17'h1FFFF;

  // ****************************************************************
  // command opcodes (bits 15:8 of the operation word; go, no-op and control read are whole 16-bit words)
  // ****************************************************************
  localparam logic [7:0] OP_READ = 8'h19;
  localparam logic [7:0] OP_WRITE = 8'h18;
  localparam logic [7:0] OP_DUMP = 8'h1D;
  localparam logic [7:0] OP_FILL = 8'h1C;
  localparam logic [15:0] OP_GO = 16'h0C00;
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [15:0] OP_CREG_RD = 16'h2980;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SIZE_LSB = 6;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;
  localparam int CREG_SEL_BITS = 12;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [4:0] ATTR_RESET = 5'h05;
  localparam logic [31:0] PTR_RESET = 32'h00000000;

  // ****************************************************************
  // command history for the block-transfer legality check
  // ****************************************************************
  typedef enum logic [2:0] {
    LAST_OTHER = 3'h0,
    LAST_READ = 3'h1,
    LAST_WRITE = 3'h2
  } sdm_last_type;

  typedef enum logic [5:0] {
    ST_CMD = 6'h01,
    ST_ADDR_HI = 6'h02,
    ST_ADDR_LO = 6'h04,
    ST_DATA = 6'h08,
    ST_BUS = 6'h10,
    ST_RESULT = 6'h20
  } sdm_state_type;

endpackage

// ==== sdm_shifter.sv ====
// sdm_shifter: 17-bit serial shift engine for the debug link.
// assumes link clock and data arrive asynchronously; all are sampled on clk_i.
`timescale 1ns/1ps
`default_nettype none
module sdm_shifter
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic link_din_i,
  input wire logic [16:0] tx_word_i,
  output logic link_dout_o,
  output logic [16:0] rx_word_o,
  output logic rx_done_o,
  output logic frame_start_o
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [1:0] clk_sync_ff;
  logic [1:0] din_sync_ff;
  logic clk_last_ff;
  logic [16:0] sh_ff;
  logic [4:0] cnt_ff;
  logic [16:0] tx_ff;
  wire rise = clk_sync_ff[1] & ~clk_last_ff;
  wire fall = ~clk_sync_ff[1] & clk_last_ff;
  wire last_bit = (cnt_ff == 5'(FRAME_BITS - 1));

  // opening edge of a frame: the response word is latched at this very edge
  assign frame_start_o = rise && (cnt_ff == 5'h00);

  // two flops before any logic looks at the pins
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      clk_sync_ff <= 2'h0;
      din_sync_ff <= 2'h0;
      clk_last_ff <= 1'b0;
    end
    else
    begin
      clk_sync_ff <= {clk_sync_ff[0], link_clk_i};
      din_sync_ff <= {din_sync_ff[0], link_din_i};
      clk_last_ff <= clk_sync_ff[1];
    end
  end

  // ****************************************************************
  // shift: capture on rising edge, drive msb first on falling edge
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sh_ff <= 17'h00000;
      cnt_ff <= 5'h00;
      tx_ff <= RSP_COMPLETE;
      rx_word_o <= 17'h00000;
      rx_done_o <= 1'b0;
      link_dout_o <= 1'b0;
    end
    else
    begin
      rx_done_o <= 1'b0;
      if (rise)
      begin
        sh_ff <= {sh_ff[15:0], din_sync_ff[1]};
        if (cnt_ff == 5'h00)
          tx_ff <= tx_word_i; // response latched as frame starts
        if (last_bit)
        begin
          cnt_ff <= 5'h00;
          rx_word_o <= {sh_ff[15:0], din_sync_ff[1]};
          rx_done_o <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 5'h01;
      end
      // host and device bits overlap in the same frame
      if (cnt_ff == 5'h00 && !clk_sync_ff[1])
        link_dout_o <= tx_word_i[16];
      else if (fall)
        link_dout_o <= tx_ff[5'(FRAME_BITS - 1) - cnt_ff];
    end
  end

endmodule
`default_nettype wire

// ==== sdm_engine.sv ====
// sdm_engine: command engine of the serial background debug port.
// assumes a host shifting 17-bit frames and a system bus that answers each
// request with one done pulse, optionally flagged as bus error.
// the host must repeat anything it shifted during a bus access, while the answer was not ready;
// a frame cut short leaves the shifter waiting for its remaining bits.
//
// Operation
// - byte reads return data in low byte; word 16 bits, long 32 bits.
// - good read answers have bit 16 clear; bus error gives error pattern.
// - write address space comes from low five attribute bits.
// - word and long addresses have low bits forced to zero.
// - good write answers complete; bus error answers error pattern.
// - read leaves pointer advanced by size; dump reads and advances it.
// - dump only legal after dump, no-op or read; else illegal.
// - no-op leaves the block pointer untouched.
// - size field decoded anew on each dump.
// - dump has no operands and answers like a read.
// - write leaves pointer advanced by size; fill writes and advances it.
// - fill only legal after fill, no-op or write; else illegal.
// - size field decoded anew on each fill.
// - fill takes one data operand; answers complete or error.
// - resume pulses core restart using current program counter and status.
// - resume and no-op answer complete in the next frame.
// - no-op changes nothing but its answer.
// - control register read always returns 32 bits.
// - control read issues special cycle with 12-bit selector.
// - every word is one 17-bit frame, overlapped both ways.
// - frames during a bus access answer not ready.
// - size codes 0, 1, 2 mean byte, word, long; 3 reserved.
// - multi-word values travel most significant word first.
`timescale 1ns/1ps
`default_nettype none
module sdm_engine
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic link_din_i,
  output logic link_dout_o,
  input wire logic [4:0] debug_address_attributes_i,
  output logic bus_req_o,
  output logic bus_we_o,
  output logic bus_creg_o,
  output logic [31:0] bus_addr_o,
  output logic [1:0] bus_size_o,
  output logic [4:0] bus_attr_o,
  output logic [31:0] bus_wdata_o,
  input wire logic bus_done_i,
  input wire logic bus_err_i,
  input wire logic [31:0] bus_rdata_i,
  output logic core_resume_o,
  output logic [31:0] high_address_breakpoint_o
);
  import sdm_pkg::*;

  // ****************************************************************
  // serial shifter
  // ****************************************************************
  logic [16:0] rx_word;
  logic rx_done;
  logic [16:0] rsp_ff;
  logic frame_start;

  // the shifter latches rsp_ff as each frame opens, so a value posted
  // later in that frame waits for the next one
  sdm_shifter u_shift (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .link_clk_i(link_clk_i),
    .link_din_i(link_din_i),
    .tx_word_i(rsp_ff),
    .link_dout_o(link_dout_o),
    .rx_word_o(rx_word),
    .rx_done_o(rx_done),
    .frame_start_o(frame_start)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  sdm_state_type state_ff;
  sdm_last_type last_ff;
  logic [15:0] cmd_ff;
  logic [31:0] addr_ff;
  logic [31:0] data_ff;
  logic [31:0] rdata_ff;
  logic data_hi_ff;
  logic res_lo_ff;
  logic [31:0] ptr_ff;

  // ****************************************************************
  // result tracking
  // ****************************************************************
  // replay re-decodes the opcode that rode on the last result frame;
  // sent marks that the frame now shifting opened after the result was posted
  logic replay_ff;
  logic sent_ff;

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire [7:0] rx_op = rx_word[15:8];
  wire [1:0] rx_size = rx_word[SIZE_LSB+1:SIZE_LSB];
  wire [1:0] cmd_size = cmd_ff[SIZE_LSB+1:SIZE_LSB];
  // opcodes with the reserved size are refused before any bus cycle
  wire rx_rsvd = (rx_size == SZ_RSVD);
  wire is_read = (rx_op == OP_READ) && !rx_rsvd;
  wire is_write = (rx_op == OP_WRITE) && !rx_rsvd;
  wire is_dump = (rx_op == OP_DUMP) && !rx_rsvd;
  wire is_fill = (rx_op == OP_FILL) && !rx_rsvd;
  wire is_go = (rx_word[15:0] == OP_GO);
  wire is_nop = (rx_word[15:0] == OP_NOP);
  wire is_creg = (rx_word[15:0] == OP_CREG_RD);
  // block commands only chain onto their own kind; nop keeps the chain
  wire dump_ok = is_dump && (last_ff == LAST_READ);
  wire fill_ok = is_fill && (last_ff == LAST_WRITE);
  // decode of the command held while its operands arrive
  wire cmd_is_write = (cmd_ff[15:8] == OP_WRITE) || (cmd_ff[15:8] == OP_FILL);
  wire cmd_is_creg = (cmd_ff == OP_CREG_RD);
  wire cmd_long = (cmd_size == SZ_LONG) || cmd_is_creg;

  // size increment and natural alignment
  wire [31:0] size_inc = (cmd_size == SZ_BYTE) ? 32'h00000001 :
                         (cmd_size == SZ_WORD) ? 32'h00000002 : 32'h00000004;
  wire [31:0] aligned = (cmd_size == SZ_BYTE) ? addr_ff :
                        (cmd_size == SZ_WORD) ? {addr_ff[31:1], 1'b0} :
                        {addr_ff[31:2], 2'h0};
  // the pointer wraps at the top of the address space; no carry is kept
  wire [31:0] next_ptr = aligned + size_inc;

  // read answers: byte in low byte, word 16 bits, long high word first
  wire [16:0] rd_first = cmd_long ? {1'b0, rdata_ff[31:16]} :
                         (cmd_size == SZ_BYTE) ? {9'h000, rdata_ff[7:0]} :
                         {1'b0, rdata_ff[15:0]};
  wire [16:0] rd_second = {1'b0, rdata_ff[15:0]};

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= ST_CMD;
      last_ff <= LAST_OTHER;
      cmd_ff <= OP_NOP;
      addr_ff <= PTR_RESET;
      data_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
      data_hi_ff <= 1'b0;
      res_lo_ff <= 1'b0;
      ptr_ff <= PTR_RESET;
      replay_ff <= 1'b0;
      sent_ff <= 1'b0;
      rsp_ff <= RSP_COMPLETE;
      bus_req_o <= 1'b0;
      bus_we_o <= 1'b0;
      bus_creg_o <= 1'b0;
      bus_addr_o <= 32'h00000000;
      bus_size_o <= SZ_BYTE;
      bus_attr_o <= ATTR_RESET;
      bus_wdata_o <= 32'h00000000;
      core_resume_o <= 1'b0;
    end
    else
    begin
      core_resume_o <= 1'b0;
      case (state_ff)
        // idle: decode a fresh opcode, or the one that rode on the last result frame
        ST_CMD:
        begin
          replay_ff <= 1'b0;
          if (rx_done || replay_ff)
          begin
            cmd_ff <= rx_word[15:0];
            data_hi_ff <= 1'b0;
            rsp_ff <= RSP_NOT_READY;
            if (is_read || is_write || is_creg)
            begin
              state_ff <= ST_ADDR_HI;
            end
            else if (dump_ok)
            begin
              // dump reads at the saved pointer with the size of this command
              addr_ff <= ptr_ff;
              state_ff <= ST_BUS;
            end
            else if (fill_ok)
            begin
              // fill still needs its data operand before the write
              addr_ff <= ptr_ff;
              data_hi_ff <= (rx_size == SZ_LONG);
              state_ff <= ST_DATA;
            end
            else if (is_go)
            begin
              // a pulse only; the core restarts from its own program counter and status
              core_resume_o <= 1'b1;
              rsp_ff <= RSP_COMPLETE;
              last_ff <= LAST_OTHER;
            end
            else if (is_nop)
            begin
              rsp_ff <= RSP_COMPLETE;
            end
            else
            begin
              // anything else is refused without a bus cycle and breaks the chain
              rsp_ff <= RSP_ILLEGAL;
              last_ff <= LAST_OTHER;
            end
          end
        end
        // first address operand: upper half of the absolute address
        ST_ADDR_HI:
        begin
          if (rx_done)
          begin
            addr_ff[31:16] <= rx_word[15:0];
            state_ff <= ST_ADDR_LO;
          end
        end
        // second address operand; for a control read it holds the selector
        ST_ADDR_LO:
        begin
          if (rx_done)
          begin
            addr_ff[15:0] <= rx_word[15:0];
            data_hi_ff <= cmd_long;
            state_ff <= cmd_is_write ? ST_DATA : ST_BUS;
          end
        end
        // write data; a byte sits in the low eight bits of its word
        ST_DATA:
        begin
          if (rx_done)
          begin
            // long data arrives high word first
            if (data_hi_ff)
            begin
              data_ff[31:16] <= rx_word[15:0];
              data_hi_ff <= 1'b0;
            end
            else
            begin
              data_ff[15:0] <= rx_word[15:0];
              state_ff <= ST_BUS;
            end
          end
        end
        // one request per command; frames during it answer not ready
        ST_BUS:
        begin
          rsp_ff <= RSP_NOT_READY;
          sent_ff <= 1'b0;
          // attributes are sampled as the request rises, so a change
          // during an access only affects the next one
          if (!bus_req_o && !bus_done_i)
          begin
            bus_req_o <= 1'b1;
            bus_we_o <= cmd_is_write;
            bus_creg_o <= cmd_is_creg;
            bus_addr_o <= cmd_is_creg ? {20'h00000, addr_ff[CREG_SEL_BITS-1:0]} : aligned;
            bus_size_o <= cmd_is_creg ? SZ_LONG : cmd_size;
            bus_attr_o <= debug_address_attributes_i;
            bus_wdata_o <= data_ff;
          end
          if (bus_req_o && bus_done_i)
          begin
            bus_req_o <= 1'b0;
            rdata_ff <= bus_rdata_i;
            res_lo_ff <= 1'b0;
            state_ff <= ST_RESULT;
            // pointer saved only when the access succeeds
            if (!cmd_is_creg && !bus_err_i)
              ptr_ff <= next_ptr;
            // an error or a control read breaks the chain, so a later
            // dump or fill must start again from a read or a write
            if (cmd_is_creg || bus_err_i)
              last_ff <= LAST_OTHER;
            else
              last_ff <= cmd_is_write ? LAST_WRITE : LAST_READ;
            if (bus_err_i)
              rsp_ff <= cmd_is_write ? RSP_BUS_ERROR : RSP_BUS_ERROR;
            else if (cmd_is_write)
              rsp_ff <= RSP_COMPLETE;
          end
        end
        // result frames: writes and errors have one, long reads have two
        ST_RESULT:
        begin
          // a frame opened before the result was posted carried only not-ready
          if (frame_start && rsp_ff != RSP_NOT_READY)
            sent_ff <= 1'b1;
          // not-ready stays until the result is posted for the next frame
          if (!res_lo_ff && !bus_err_i && !cmd_is_write && rsp_ff == RSP_NOT_READY)
          begin
            rsp_ff <= rd_first;
            res_lo_ff <= !cmd_long;
          end
          else if (rx_done && sent_ff)
          begin
            sent_ff <= 1'b0;
            if (cmd_long && !cmd_is_write && !res_lo_ff && rsp_ff != RSP_BUS_ERROR)
            begin
              // high word has gone out; the low word follows in the next frame
              rsp_ff <= rd_second;
              res_lo_ff <= 1'b1;
            end
            else
            begin
              // this frame carried the next opcode: idle decodes it at once
              state_ff <= ST_CMD;
              res_lo_ff <= 1'b0;
              replay_ff <= 1'b1;
            end
          end
        end
        // an unknown state code falls back to idle instead of hanging the link
        default:
        begin
          state_ff <= ST_CMD;
        end
      endcase
    end
  end

  // pointer exposed as the high address breakpoint value
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      high_address_breakpoint_o <= PTR_RESET;
    else
      high_address_breakpoint_o <= ptr_ff;
  end

endmodule
`default_nettype wire

// ==== sdm_chk_asserts.sv ====
// sdm_chk: concurrent checks on the bus side of the debug command engine.
// assumes one clock domain and the port names of sdm_engine; attached by bind.
`timescale 1ns/1ps
`default_nettype none
module sdm_chk
  import sdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [4:0] debug_address_attributes_i,
  input wire logic bus_req_o,
  input wire logic bus_we_o,
  input wire logic bus_creg_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [1:0] bus_size_o,
  input wire logic [4:0] bus_attr_o,
  input wire logic bus_done_i,
  input wire logic bus_err_i,
  input wire logic core_resume_o,
  input wire logic [31:0] high_address_breakpoint_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ********
  // pointer cause tracking
  // ********
  // cycles since the last good completion; the pointer may only move just after one
  logic [2:0] since_ok_ff;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      since_ok_ff <= 3'h7;
    else if (bus_done_i && !bus_err_i)
      since_ok_ff <= 3'h0;
    else if (since_ok_ff != 3'h7)
      since_ok_ff <= since_ok_ff + 3'h1;
  end
  // ********
  // assertions
  // ********
  chk_word_align: assert property (bus_req_o && bus_size_o == SZ_WORD |-> !bus_addr_o[0])
    else $error("word access on odd address");
  chk_long_align: assert property (
    bus_req_o && !bus_creg_o && bus_size_o == SZ_LONG |-> bus_addr_o[1:0] == 2'h0)
    else $error("long access off a four-byte boundary");
  chk_attr_copy: assert property (
    bus_req_o && !bus_creg_o |-> bus_attr_o == debug_address_attributes_i)
    else $error("bus attributes differ from attribute input");
  chk_size_legal: assert property (bus_req_o |-> bus_size_o != SZ_RSVD)
    else $error("bus cycle with reserved size");
  chk_creg_long: assert property (bus_req_o && bus_creg_o |-> bus_size_o == SZ_LONG && !bus_we_o)
    else $error("control read not a long read");
  chk_resume_pulse: assert property (core_resume_o |-> !bus_req_o ##1 !core_resume_o)
    else $error("resume pulse too long or beside a bus cycle");
  chk_req_held: assert property (
    bus_req_o && !bus_done_i |=> bus_req_o && $stable(bus_addr_o) && $stable(bus_we_o))
    else $error("bus request dropped or changed before done");
  chk_req_ends: assert property (bus_done_i && bus_req_o |-> ##[1:2] !bus_req_o)
    else $error("bus request outlives its done");
  chk_ptr_cause: assert property (
    $changed(high_address_breakpoint_o) |-> since_ok_ff <= 3'h2)
    else $error("pointer moved without a good completion");
endmodule
`default_nettype wire

// ==== sdm_host.sv ====
// sdm_host: debug host model shifting 17-bit frames over the serial link.
// assumes the device samples on link clock rise and moves its bit on fall.
`timescale 1ns/1ps
`default_nettype none
module sdm_host
(
  output logic link_clk_o,
  output logic link_din_o,
  input wire logic link_dout_i
);
  // ********
  // frame transfer
  // ********
  initial
  begin
    link_clk_o = 1'b0;
    link_din_o = 1'b1;
  end
  // clock stands low between frames; gap is over forty-eight system clocks, off its phase
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    #241;
    for (int i = 16; i >= 0; i--)
    begin
      link_din_o = tx[i];
      #80 link_clk_o = 1'b1;
      #78 rx[i] = link_dout_i;
      #2 link_clk_o = 1'b0;
    end
    // released line shows the inverse so a stale bit cannot pass
    #80 link_din_o = ~tx[0];
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for the serial debug memory command engine.
// assumes sdm_pkg, sdm_engine, sdm_host and sdm_chk are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sdm_pkg::*;
  // ********
  // design, host and bus partner
  // ********
  logic clk_i, nrst_i, link_clk_i, link_din_i, link_dout_o, bus_req_o, bus_we_o, bus_creg_o;
  logic bus_done_i, bus_err_i, core_resume_o, err_on;
  logic [1:0] bus_size_o;
  logic [4:0] debug_address_attributes_i, bus_attr_o;
  logic [31:0] bus_addr_o, bus_wdata_o, bus_rdata_i, high_address_breakpoint_o, c_wdata;
  logic [40:0] cap;
  logic [16:0] rsp[$];
  int n_errors, n_compared, n_bus, n_res, lat, wcnt, nb, nr;
  sdm_engine u_sdm_engine (.clk_i, .nrst_i, .link_clk_i, .link_din_i, .link_dout_o,
    .debug_address_attributes_i, .bus_req_o, .bus_we_o, .bus_creg_o, .bus_addr_o,
    .bus_size_o, .bus_attr_o, .bus_wdata_o, .bus_done_i, .bus_err_i, .bus_rdata_i,
    .core_resume_o, .high_address_breakpoint_o);
  sdm_host u_sdm_host (.link_clk_o(link_clk_i), .link_din_o(link_din_i), .link_dout_i(link_dout_o));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // high word is the low address half, so word order shows on the link
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], a[7:0] ^ 8'h5A, a[7:0] ^ 8'h5A};
  endfunction
  // bus partner: one done pulse per request after lat cycles; data churns otherwise
  always @(posedge clk_i)
  begin
    bus_done_i <= 1'b0;
    bus_err_i <= 1'b0;
    bus_rdata_i <= ~bus_rdata_i;
    if (core_resume_o) n_res++;
    if (bus_req_o && !bus_done_i && wcnt < lat) wcnt++;
    else if (bus_req_o && !bus_done_i)
    begin
      wcnt = 0;
      n_bus++;
      cap = {bus_we_o, bus_creg_o, bus_size_o, bus_attr_o, bus_addr_o};
      c_wdata = bus_wdata_o;
      bus_done_i <= 1'b1;
      bus_err_i <= err_on;
      bus_rdata_i <= pat(bus_addr_o);
    end
  end
  // ********
  // checks and link transactions
  // ********
  task automatic chk(input string what, input logic [40:0] seen, input logic [40:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a command with operands and result frames; every response is kept
  task automatic run(input logic [15:0] w[$]);
    logic [16:0] r;
    rsp.delete();
    foreach (w[i])
    begin
      @(negedge clk_i);
      u_sdm_host.xfer({1'b0, w[i]}, r);
      rsp.push_back(r);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial
  begin
    #400000;
    n_errors++;
    print_verdict();
  end
  // ********
  // scenarios
  // ********
  initial
  begin
    nrst_i = 1'b0;
    debug_address_attributes_i = 5'h0B;
    bus_done_i = 1'b0;
    bus_err_i = 1'b0;
    bus_rdata_i = 32'h0;
    err_on = 1'b0;
    lat = 2;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    // unaligned long read, then dumps of changing size with a nop between
    run('{16'h1980, 16'h1234, 16'h5677, 16'h0, 16'h0});
    chk("rd bus", cap, {2'h0, SZ_LONG, 5'h0B, 32'h12345674});
    chk("rd hi", rsp[3], 17'h05674);
    chk("rd lo", rsp[4], 17'h02E2E);
    chk("ptr rd", high_address_breakpoint_o, 32'h12345678);
    run('{16'h1D40, 16'h0});
    chk("overlap nop", rsp[0], RSP_COMPLETE);
    chk("dump word", rsp[1], 17'h02222);
    chk("ptr word", high_address_breakpoint_o, 32'h1234567A);
    run('{16'h0, 16'h1D00, 16'h0});
    chk("nop", rsp[1], RSP_COMPLETE);
    chk("dump bus", cap, {2'h0, SZ_BYTE, 5'h0B, 32'h1234567A});
    chk("dump byte", {rsp[2][16], rsp[2][7:0]}, 9'h020);
    chk("ptr byte", high_address_breakpoint_o, 32'h1234567B);
    // refused commands start no bus cycle
    nb = n_bus;
    run('{16'h1C40, 16'h0});
    chk("fill after dump", rsp[1], RSP_ILLEGAL);
    run('{16'h19C0, 16'h0});
    chk("rsvd size", rsp[1], RSP_ILLEGAL);
    chk("no cycle", n_bus, nb);
    err_on = 1'b1;
    run('{16'h1940, 16'h0, 16'h2000, 16'h0});
    chk("rd error", rsp[3], RSP_BUS_ERROR);
    chk("ptr kept", high_address_breakpoint_o, 32'h1234567B);
    err_on = 1'b0;
    // byte write under new attributes, then fills of growing size
    @(posedge clk_i) debug_address_attributes_i <= 5'h15;
    run('{16'h1800, 16'h0, 16'h1001, 16'h00AB, 16'h0});
    chk("wr bus", cap, {2'h2, SZ_BYTE, 5'h15, 32'h00001001});
    chk("wr byte", c_wdata[7:0], 8'hAB);
    chk("wr status", rsp[4], RSP_COMPLETE);
    run('{16'h1C40, 16'hBEEF, 16'h0});
    chk("fill bus", cap, {2'h2, SZ_WORD, 5'h15, 32'h00001002});
    chk("fill word", c_wdata[15:0], 16'hBEEF);
    chk("fill status", rsp[2], RSP_COMPLETE);
    run('{16'h1C80, 16'hCAFE, 16'hF00D, 16'h0});
    chk("fill long bus", cap, {2'h2, SZ_LONG, 5'h15, 32'h00001004});
    chk("fill long", c_wdata, 32'hCAFEF00D);
    chk("ptr fill", high_address_breakpoint_o, 32'h00001008);
    nb = n_bus;
    run('{16'h1D00, 16'h0});
    chk("dump after fill", rsp[1], RSP_ILLEGAL);
    chk("no dump cycle", n_bus, nb);
    err_on = 1'b1;
    run('{16'h1840, 16'h0, 16'h2002, 16'h1111, 16'h0});
    chk("wr error", rsp[4], RSP_BUS_ERROR);
    err_on = 1'b0;
    // resume and nop: complete answers, no bus traffic
    nb = n_bus;
    nr = n_res;
    run('{16'h0C00, 16'h0, 16'h0});
    chk("go status", rsp[1], RSP_COMPLETE);
    chk("resume", n_res, nr + 1);
    chk("nop status", rsp[2], RSP_COMPLETE);
    chk("quiet bus", n_bus, nb);
    run('{16'h2980, 16'h0, 16'h080E, 16'h0, 16'h0});
    chk("creg kind", cap[40:37], 4'h6);
    chk("creg sel", cap[11:0], 12'h80E);
    chk("creg hi", rsp[3], 17'h0080E);
    chk("creg lo", rsp[4], 17'h05454);
    // slow bus: the frame during the access answers not ready
    lat = 200;
    run('{16'h1980, 16'h0, 16'h3000, 16'h0, 16'h0, 16'h0});
    chk("not ready", rsp[3], RSP_NOT_READY);
    chk("late hi", rsp[4], 17'h03000);
    chk("late lo", rsp[5], 17'h05A5A);
    print_verdict();
  end
endmodule
bind sdm_engine sdm_chk u_sdm_chk (.clk_i, .nrst_i, .debug_address_attributes_i, .bus_req_o,
  .bus_we_o, .bus_creg_o, .bus_addr_o, .bus_size_o, .bus_attr_o, .bus_done_i, .bus_err_i,
  .core_resume_o, .high_address_breakpoint_o);
`default_nettype wire
